// file: inc/mfs_pkg.sv
package mfs_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [39:0] mfs_cnt_t;
    typedef logic [7:0]  mfs_code_t;

    typedef enum logic [1:0] {
        MFS_MUTE_UNLIMITED,
        MFS_MUTE_SHORT,
        MFS_MUTE_MID,
        MFS_MUTE_LONG
    } mfs_mute_sel_t;

    typedef enum logic [1:0] {
        MFS_START,
        MFS_WAIT,
        MFS_RUN,
        MFS_LOCK
    } mfs_state_t;

    // closed contact / actuated sensor reads as 1
    typedef struct packed {
        logic       override_closed;
        logic       lamp_open;
        logic       lamp_short;
        logic       fb_first;
        logic       fb_second;
        logic       permit;
        logic [1:0] pair_a;
        logic [1:0] pair_b;
        logic [1:0] stop_ch;
        logic       reset_closed;
    } mfs_in_t;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint unsigned MFS_CLK_HZ      = 250_000_000;
    localparam longint unsigned FB_LIMIT_MS     = 200;
    localparam longint unsigned SENSOR_GAP_MS   = 3000;
    localparam longint unsigned STOP_SKEW_MS    = 3000;
    localparam longint unsigned RESET_MIN_MS    = 250;
    localparam longint unsigned RESET_MAX_MS    = 2000;
    localparam longint unsigned MUTE_SHORT_MS   = 30000;
    localparam longint unsigned MUTE_MID_MS     = 60000;
    localparam longint unsigned MUTE_LONG_MS    = 1800000;
    localparam longint unsigned FLASH_HALF_MS   = 250;
    localparam int              FILT_LEN        = 4;
    localparam logic [3:0]      START_WAIT      = 4'h8;

    function automatic mfs_cnt_t mfs_ms_to_cyc(input longint unsigned ms);
        return mfs_cnt_t'((ms * MFS_CLK_HZ) / 1000);
    endfunction

    // ------------------------------------------------------------
    // diagnostic codes (decimal value shown on the display)
    // ------------------------------------------------------------
    localparam mfs_code_t CODE_NONE      = 8'h00;
    localparam mfs_code_t CODE_OVERRIDE  = 8'h23;
    localparam mfs_code_t CODE_LAMP      = 8'h24;
    localparam mfs_code_t CODE_FB_FIRST  = 8'h26;
    localparam mfs_code_t CODE_FB_SECOND = 8'h27;
    localparam mfs_code_t CODE_FB_PAIR   = 8'h28;
    localparam mfs_code_t CODE_MUTE_TIME = 8'h32;
    localparam mfs_code_t CODE_MUTE_SIM  = 8'h33;
    localparam mfs_code_t CODE_PERMIT    = 8'h34;
    localparam mfs_code_t CODE_STOP      = 8'h3d;

endpackage

// file: rtl/mfs_filter.sv
`timescale 1ns/1ps
module mfs_filter
    import mfs_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] clean
);

    // ------------------------------------------------------------
    // sync stage then agreement window
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] hist      [FILT_LEN];
    logic [WIDTH-1:0] next_clean;
    logic [WIDTH-1:0] all_one;
    logic [WIDTH-1:0] all_zero;

    // a level changes clean only after FILT_LEN equal samples
    always_comb begin
        all_one  = '1;
        all_zero = '1;
        for (int i = 0; i < FILT_LEN; i++) begin
            all_one  = all_one & hist[i];
            all_zero = all_zero & ~hist[i];
        end
        next_clean = (clean | all_one) & ~all_zero; // RULE_16
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            meta  <= '0;
            clean <= '0;
            for (int i = 0; i < FILT_LEN; i++) begin
                hist[i] <= '0;
            end
        end else begin
            meta    <= raw;
            hist[0] <= meta;
            for (int i = 1; i < FILT_LEN; i++) begin
                hist[i] <= hist[i-1];
            end
            clean <= next_clean;
        end
    end

endmodule

// file: rtl/mfs_supervisor.sv
`timescale 1ns/1ps
// Function
// RULE_01: override closed at power-up locks, code 35
// RULE_02: mute lamp open or short locks, code 36
// RULE_03: first feedback transition over 200 ms, code 38
// RULE_04: dropout check: first feedback open late, 38
// RULE_05: first feedback not closed at startup, code 38
// RULE_06: second feedback misuse or open at startup, 39
// RULE_07: two-channel skew or both open late, 40
// RULE_08: mute duration expiry ends muting, code 50
// RULE_09: sensor pair gap over 3 s, code 51
// RULE_10: mute attempt without permit refused, code 52
// RULE_11: protective stop channel disagreement, code 61
// RULE_12: lockout drops outputs, flashes red, shows code
// RULE_13: reset accepted after 1/4 to 2 s hold
// RULE_14: stop fault clears after open-to-closed cycle
// RULE_15: first detected code latched until cleared
// RULE_16: inputs synchronised and filtered before timers
module mfs_supervisor
    import mfs_pkg::*;
#(
    parameter mfs_cnt_t FB_LIMIT_CYC   = mfs_ms_to_cyc(FB_LIMIT_MS),
    parameter mfs_cnt_t SENSOR_GAP_CYC = mfs_ms_to_cyc(SENSOR_GAP_MS),
    parameter mfs_cnt_t STOP_SKEW_CYC  = mfs_ms_to_cyc(STOP_SKEW_MS),
    parameter mfs_cnt_t RESET_MIN_CYC  = mfs_ms_to_cyc(RESET_MIN_MS),
    parameter mfs_cnt_t RESET_MAX_CYC  = mfs_ms_to_cyc(RESET_MAX_MS),
    parameter mfs_cnt_t MUTE_SHORT_CYC = mfs_ms_to_cyc(MUTE_SHORT_MS),
    parameter mfs_cnt_t MUTE_MID_CYC   = mfs_ms_to_cyc(MUTE_MID_MS),
    parameter mfs_cnt_t MUTE_LONG_CYC  = mfs_ms_to_cyc(MUTE_LONG_MS),
    parameter mfs_cnt_t FLASH_HALF_CYC = mfs_ms_to_cyc(FLASH_HALF_MS)
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          override_closed,
    input  wire logic          lamp_open,
    input  wire logic          lamp_short,
    input  wire logic          contactor_feedback_first,
    input  wire logic          contactor_feedback_second,
    input  wire logic          two_channel_mode,
    input  wire logic          dropout_check_en,
    input  wire logic          mute_permit,
    input  wire logic [1:0]    mute_sensor_pair_a,
    input  wire logic [1:0]    mute_sensor_pair_b,
    input  wire mfs_mute_sel_t mute_limit_sel,
    input  wire logic [1:0]    protective_stop_input,
    input  wire logic          reset_closed,
    output logic [1:0]         safety_output_pair,
    output logic               lockout,
    output logic               red_indicator,
    output logic               mute_active,
    output mfs_code_t          diag_code
);

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    mfs_in_t raw_in;
    mfs_in_t f;

    assign raw_in = '{override_closed, lamp_open, lamp_short, contactor_feedback_first,
                      contactor_feedback_second, mute_permit, mute_sensor_pair_a,
                      mute_sensor_pair_b, protective_stop_input, reset_closed};

    mfs_filter #(.WIDTH($bits(mfs_in_t))) u_filter (
        .clock (clock),
        .rst   (rst),
        .raw   (raw_in),
        .clean (f)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic mfs_cnt_t sat_inc(input mfs_cnt_t c, input logic run);
        if (!run) begin
            return '0;
        end
        return (c == '1) ? c : c + 40'h00_0000_0001;
    endfunction

    function automatic mfs_cnt_t mute_limit(input mfs_mute_sel_t sel);
        unique case (sel)
            MFS_MUTE_UNLIMITED: return '1;
            MFS_MUTE_SHORT:     return MUTE_SHORT_CYC;
            MFS_MUTE_MID:       return MUTE_MID_CYC;
            MFS_MUTE_LONG:      return MUTE_LONG_CYC;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mfs_state_t state,       next_state;
    logic [3:0] start_cnt,   next_start_cnt;
    mfs_cnt_t   fb1_cnt,     next_fb1_cnt;
    mfs_cnt_t   skew_cnt,    next_skew_cnt;
    mfs_cnt_t   both_cnt,    next_both_cnt;
    mfs_cnt_t   gap_cnt [2];
    mfs_cnt_t   next_gap_cnt [2];
    mfs_cnt_t   mute_cnt,    next_mute_cnt;
    mfs_cnt_t   stop_cnt,    next_stop_cnt;
    mfs_cnt_t   hold_cnt,    next_hold_cnt;
    mfs_cnt_t   flash_cnt,   next_flash_cnt;
    logic       reset_prev,  next_reset_prev;
    logic       reset_ok,    next_reset_ok;
    logic       stop_seen_open, next_stop_seen_open;
    logic [1:0] next_safety_output_pair;
    logic       next_lockout;
    logic       next_red_indicator;
    logic       next_mute_active;
    mfs_code_t  next_diag_code;
    mfs_code_t  first_code;
    logic       start_check;
    logic       outputs_on;
    logic       mute_try;
    logic       mute_hold;
    logic       stop_closed;
    logic [1:0] pair_both;

    always_comb begin
        next_state          = state;
        next_start_cnt      = start_cnt;
        next_reset_prev     = f.reset_closed;
        next_stop_seen_open = stop_seen_open;
        next_diag_code      = diag_code;
        next_mute_active    = mute_active;
        next_flash_cnt      = '0;
        next_red_indicator  = 1'b1;
        first_code          = CODE_NONE;

        outputs_on  = safety_output_pair[0];
        stop_closed = &f.stop_ch;
        start_check = (state == MFS_START) && (start_cnt == START_WAIT);
        pair_both   = {&f.pair_b, &f.pair_a};
        mute_try    = |pair_both && !mute_active && (state == MFS_RUN);
        mute_hold   = |pair_both;

        // contactor contacts read closed while outputs are off
        next_fb1_cnt  = sat_inc(fb1_cnt, f.fb_first == outputs_on);
        next_skew_cnt = sat_inc(skew_cnt, f.fb_first != f.fb_second);
        next_both_cnt = sat_inc(both_cnt, !outputs_on && !f.fb_first && !f.fb_second);
        next_gap_cnt[0] = sat_inc(gap_cnt[0], ^f.pair_a);
        next_gap_cnt[1] = sat_inc(gap_cnt[1], ^f.pair_b);
        next_mute_cnt = sat_inc(mute_cnt, mute_active);
        next_stop_cnt = sat_inc(stop_cnt, ^f.stop_ch);
        next_hold_cnt = sat_inc(hold_cnt, f.reset_closed);
        // release edge closes the hold window
        next_reset_ok = reset_prev && !f.reset_closed && (hold_cnt >= RESET_MIN_CYC)
                        && (hold_cnt <= RESET_MAX_CYC); // RULE_13

        // lowest code wins when faults arrive together
        if (start_check && f.override_closed) begin
            first_code = CODE_OVERRIDE; // RULE_01
        end else if (f.lamp_open || f.lamp_short) begin
            first_code = CODE_LAMP; // RULE_02
        end else if ((fb1_cnt >= FB_LIMIT_CYC) && (outputs_on || dropout_check_en)) begin
            first_code = CODE_FB_FIRST; // RULE_03 RULE_04
        end else if (start_check && !f.fb_first) begin
            first_code = CODE_FB_FIRST; // RULE_05
        end else if ((!two_channel_mode && f.fb_second)
                     || (start_check && two_channel_mode && !f.fb_second)) begin
            first_code = CODE_FB_SECOND; // RULE_06
        end else if (two_channel_mode
                     && ((skew_cnt >= FB_LIMIT_CYC) || (both_cnt >= FB_LIMIT_CYC))) begin
            first_code = CODE_FB_PAIR; // RULE_07
        end else if (mute_active && (mute_cnt >= mute_limit(mute_limit_sel))) begin
            first_code = CODE_MUTE_TIME; // RULE_08
        end else if ((gap_cnt[0] >= SENSOR_GAP_CYC) || (gap_cnt[1] >= SENSOR_GAP_CYC)) begin
            first_code = CODE_MUTE_SIM; // RULE_09
        end else if (mute_try && !f.permit) begin
            first_code = CODE_PERMIT; // RULE_10
        end else if (stop_cnt >= STOP_SKEW_CYC) begin
            first_code = CODE_STOP; // RULE_11
        end

        unique case (state)
            MFS_START: begin
                next_start_cnt = start_cnt + 4'h1;
                if (start_check) begin
                    next_state = MFS_WAIT;
                end
            end
            MFS_WAIT: begin
                if (reset_ok && stop_closed) begin
                    next_state = MFS_RUN;
                end
            end
            MFS_RUN: begin
                if (!stop_closed) begin
                    next_state = MFS_WAIT;
                end
            end
            MFS_LOCK: begin
                // red flashes while locked
                next_flash_cnt     = (flash_cnt >= FLASH_HALF_CYC) ? '0 : flash_cnt + 40'h1;
                next_red_indicator = (flash_cnt >= FLASH_HALF_CYC) ? !red_indicator
                                                                   : red_indicator; // RULE_12
                if (f.stop_ch == 2'b00) begin
                    next_stop_seen_open = 1'b1;
                end
                if (diag_code == CODE_STOP) begin
                    if (stop_seen_open && stop_closed) begin
                        next_state = MFS_WAIT; // RULE_14
                    end
                end else if (reset_ok && (first_code == CODE_NONE)) begin
                    next_state = MFS_WAIT; // RULE_13
                end
            end
        endcase

        if (mute_try && f.permit && (first_code == CODE_NONE)) begin
            next_mute_active = 1'b1;
        end else if (!mute_hold || (state != MFS_RUN)) begin
            next_mute_active = 1'b0;
        end

        if ((state != MFS_LOCK) && (first_code != CODE_NONE)) begin
            next_state          = MFS_LOCK;
            next_diag_code      = first_code; // RULE_15
            next_mute_active    = 1'b0; // RULE_08
            next_stop_seen_open = 1'b0;
            next_red_indicator  = 1'b1;
        end else if ((state == MFS_LOCK) && (next_state != MFS_LOCK)) begin
            next_diag_code = CODE_NONE;
        end

        next_lockout            = (next_state == MFS_LOCK); // RULE_12
        next_safety_output_pair = (next_state == MFS_RUN) ? 2'b11 : 2'b00; // RULE_12
        next_red_indicator      = (next_state == MFS_RUN) ? 1'b0 : next_red_indicator; // RULE_12
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state              <= MFS_START;
            start_cnt          <= '0;
            fb1_cnt            <= '0;
            skew_cnt           <= '0;
            both_cnt           <= '0;
            gap_cnt[0]         <= '0;
            gap_cnt[1]         <= '0;
            mute_cnt           <= '0;
            stop_cnt           <= '0;
            hold_cnt           <= '0;
            flash_cnt          <= '0;
            reset_prev         <= 1'b0;
            reset_ok           <= 1'b0;
            stop_seen_open     <= 1'b0;
            safety_output_pair <= 2'b00;
            lockout            <= 1'b0;
            red_indicator      <= 1'b1;
            mute_active        <= 1'b0;
            diag_code          <= CODE_NONE;
        end else begin
            state              <= next_state;
            start_cnt          <= next_start_cnt;
            fb1_cnt            <= next_fb1_cnt;
            skew_cnt           <= next_skew_cnt;
            both_cnt           <= next_both_cnt;
            gap_cnt[0]         <= next_gap_cnt[0];
            gap_cnt[1]         <= next_gap_cnt[1];
            mute_cnt           <= next_mute_cnt;
            stop_cnt           <= next_stop_cnt;
            hold_cnt           <= next_hold_cnt;
            flash_cnt          <= next_flash_cnt;
            reset_prev         <= next_reset_prev;
            reset_ok           <= next_reset_ok;
            stop_seen_open     <= next_stop_seen_open;
            safety_output_pair <= next_safety_output_pair;
            lockout            <= next_lockout;
            red_indicator      <= next_red_indicator;
            mute_active        <= next_mute_active;
            diag_code          <= next_diag_code;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_lock_outputs_off: assert property (lockout |-> safety_output_pair == 2'b00) // RULE_12
        else $error("outputs on during lockout");
    chk_lock_code_held: assert property (lockout && $past(lockout) |-> $stable(diag_code)) // RULE_15
        else $error("code changed during lockout");
    chk_override_start: assert property (start_check && f.override_closed |=> lockout
        && diag_code == CODE_OVERRIDE) // RULE_01
        else $error("override at start not locked");
    chk_lamp_fault_lock: assert property ((f.lamp_open || f.lamp_short) && !lockout
        && !start_check |=> lockout && diag_code == CODE_LAMP) // RULE_02
        else $error("lamp fault not locked");
    chk_fb1_late_lock: assert property (!lockout && outputs_on && fb1_cnt >= FB_LIMIT_CYC
        && !start_check && !f.lamp_open && !f.lamp_short |=> lockout) // RULE_03
        else $error("slow feedback not locked");
    chk_fb2_single: assert property (!lockout && !two_channel_mode && f.fb_second
        |=> lockout) // RULE_06
        else $error("second feedback closed in single mode");
    chk_mute_needs_permit: assert property ($rose(mute_active) |-> $past(f.permit)) // RULE_10
        else $error("mute started without permit");
    chk_mute_expiry: assert property (mute_active && mute_cnt >= mute_limit(mute_limit_sel)
        |=> !mute_active ##0 lockout) // RULE_08
        else $error("mute ran past its limit");
    chk_stop_skew_lock: assert property (!lockout && stop_cnt >= STOP_SKEW_CYC
        |=> lockout) // RULE_11
        else $error("stop skew not locked");
    chk_stop_clear_cycle: assert property ($fell(lockout) && $past(diag_code) == CODE_STOP
        |-> $past(stop_seen_open) && $past(stop_closed)) // RULE_14
        else $error("stop fault cleared without cycling");
    chk_reset_window: assert property (reset_ok |-> $past(hold_cnt) >= RESET_MIN_CYC
        && $past(hold_cnt) <= RESET_MAX_CYC) // RULE_13
        else $error("reset accepted outside hold window");
    chk_red_solid_run: assert property (outputs_on |-> !red_indicator) // RULE_12
        else $error("red on while running");

    cov_lockout_entry: cover property ($rose(lockout));
    cov_mute_cycle:    cover property ($rose(mute_active) ##[1:20] $fell(mute_active));
    cov_reset_run:     cover property (reset_ok ##1 outputs_on);

endmodule

// file: verif/mfs_contactor.sv
`timescale 1ns/1ps
module mfs_contactor
    import mfs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [1:0] safety_output_pair,
    input  wire logic       two_channel_mode,
    input  wire logic [1:0] fault_mode,
    output logic            contactor_feedback_first,
    output logic            contactor_feedback_second
);
    // ------------------------------------------------------------
    // contactor history: closed while the outputs are off
    // ------------------------------------------------------------
    logic [63:0] hist;

    // contactors drop while the device is held in reset
    always_ff @(posedge clock) begin
        if (rst) begin
            hist <= '1;
        end else begin
            hist <= {hist[62:0], ~&safety_output_pair};
        end
    end

    // ------------------------------------------------------------
    // fault modes: 1 slow armature, 2 first stuck open, 3 second wrong
    // ------------------------------------------------------------
    always_comb begin
        contactor_feedback_first  = hist[2];
        contactor_feedback_second = two_channel_mode & hist[2];
        case (fault_mode)
            2'h1: contactor_feedback_first = hist[40];
            2'h2: contactor_feedback_first = 1'b0;
            2'h3: contactor_feedback_second = two_channel_mode ? hist[40] : 1'b1;
            default: ;
        endcase
    end
endmodule

// file: verif/muting_fault_supervisor_bench.sv
`timescale 1ns/1ps
module muting_fault_supervisor_bench
    import mfs_pkg::*;
;
    localparam int MUTE_S = 8'h32;
    localparam int MUTE_M = 8'h50;
    localparam int MUTE_L = 8'h78;

    logic          clock;
    logic          rst;
    mfs_in_t       in_s;
    logic          two_ch;
    logic          drop_en;
    mfs_mute_sel_t sel;
    logic [1:0]    fmode;
    logic          fb1;
    logic          fb2;
    logic [1:0]    outs;
    logic          lockout;
    logic          red;
    logic          mute_act;
    mfs_code_t     code;
    int            failures;
    int            compares;
    logic [31:0]   seed;

    mfs_supervisor #(
        .FB_LIMIT_CYC   (mfs_cnt_t'(8'h14)),
        .SENSOR_GAP_CYC (mfs_cnt_t'(8'h28)),
        .STOP_SKEW_CYC  (mfs_cnt_t'(8'h28)),
        .RESET_MIN_CYC  (mfs_cnt_t'(8'h0a)),
        .RESET_MAX_CYC  (mfs_cnt_t'(8'h1e)),
        .MUTE_SHORT_CYC (mfs_cnt_t'(MUTE_S)),
        .MUTE_MID_CYC   (mfs_cnt_t'(MUTE_M)),
        .MUTE_LONG_CYC  (mfs_cnt_t'(MUTE_L)),
        .FLASH_HALF_CYC (mfs_cnt_t'(8'h04))
    ) DUT (
        .clock                     (clock),
        .rst                       (rst),
        .override_closed           (in_s.override_closed),
        .lamp_open                 (in_s.lamp_open),
        .lamp_short                (in_s.lamp_short),
        .contactor_feedback_first  (fb1),
        .contactor_feedback_second (fb2),
        .two_channel_mode          (two_ch),
        .dropout_check_en          (drop_en),
        .mute_permit               (in_s.permit),
        .mute_sensor_pair_a        (in_s.pair_a),
        .mute_sensor_pair_b        (in_s.pair_b),
        .mute_limit_sel            (sel),
        .protective_stop_input     (in_s.stop_ch),
        .reset_closed              (in_s.reset_closed),
        .safety_output_pair        (outs),
        .lockout                   (lockout),
        .red_indicator             (red),
        .mute_active               (mute_act),
        .diag_code                 (code)
    );

    mfs_contactor partner (
        .clock                     (clock),
        .rst                       (rst),
        .safety_output_pair        (outs),
        .two_channel_mode          (two_ch),
        .fault_mode                (fmode),
        .contactor_feedback_first  (fb1),
        .contactor_feedback_second (fb2)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic mfs_code_t start_code(input int k);
        return k == 0 ? CODE_OVERRIDE : (k == 1 ? CODE_FB_FIRST : CODE_FB_SECOND);
    endfunction

    function automatic int mute_lim(input mfs_mute_sel_t s);
        case (s)
            MFS_MUTE_SHORT: return MUTE_S;
            MFS_MUTE_MID:   return MUTE_M;
            MFS_MUTE_LONG:  return MUTE_L;
            default:        return MUTE_L + 30;
        endcase
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wait_hi(ref logic s, input int n);
        int i;
        i = 0;
        while (s !== 1'b1 && i < n) begin
            @(negedge clock);
            i++;
        end
        check("awaited flag", {7'h0, s}, 8'h01);
    endtask

    // inputs held steady from release so the startup check sees them
    task automatic boot(input logic ovr, input logic tc, input logic [1:0] md);
        logic [31:0] r;
        r = xs();
        rst = 1'b1;
        in_s = '0;
        in_s.override_closed = ovr;
        in_s.stop_ch = 2'h3;
        in_s.permit = 1'b1;
        two_ch = tc;
        drop_en = r[0];
        fmode = md;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (24) @(negedge clock);
    endtask

    task automatic press(input int n);
        in_s.reset_closed = 1'b1;
        repeat (n) @(negedge clock);
        in_s.reset_closed = 1'b0;
        repeat (14) @(negedge clock);
    endtask

    task automatic press_ok();
        logic [31:0] r;
        r = xs();
        press(14 + int'(r % 12));
    endtask

    task automatic run_up(input logic tc);
        boot(1'b0, tc, 2'h0);
        press_ok();
        check("outputs on", {6'h0, outs}, 8'h03);
        check("red off", {7'h0, red}, 8'h00);
    endtask

    task automatic expect_lock(input mfs_code_t exp);
        logic r0;
        wait_hi(lockout, 300);
        check("diag code", code, exp);
        check("outputs off", {6'h0, outs}, 8'h00);
        r0 = red;
        repeat (5) @(negedge clock);
        check("red flash", {7'h0, red}, {7'h0, ~r0});
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, scenarios
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        #(4 * 20000);
        failures++;
        finish_test();
    end

    initial begin
        logic [31:0] r;
        int          k;
        failures = 0;
        compares = 0;
        seed = 32'h65a3;
        rst = 1'b1;
        in_s = '0;
        two_ch = 1'b0;
        drop_en = 1'b0;
        sel = MFS_MUTE_UNLIMITED;
        fmode = 2'h0;
        for (k = 0; k < 3; k++) begin
            boot(k == 0, 1'b0, 2'(k == 0 ? 0 : k + 1));
            expect_lock(start_code(k));
        end
        $display("test startup done");
        boot(1'b0, 1'b1, 2'h3);
        press_ok();
        expect_lock(CODE_FB_PAIR);
        boot(1'b0, 1'b0, 2'h1);
        press_ok();
        expect_lock(CODE_FB_FIRST);
        $display("test feedback done");
        boot(1'b0, 1'b0, 2'h0);
        press(6);
        check("short press", {6'h0, outs}, 8'h00);
        press(45);
        check("long press", {6'h0, outs}, 8'h00);
        press_ok();
        check("valid press", {6'h0, outs}, 8'h03);
        for (k = 1; k < 3; k++) begin
            in_s.lamp_open = k[1];
            in_s.lamp_short = k[0];
            expect_lock(CODE_LAMP);
            in_s.stop_ch = 2'h2;
            repeat (60) @(negedge clock);
            check("first code held", code, CODE_LAMP);
            in_s.lamp_open = 1'b0;
            in_s.lamp_short = 1'b0;
            in_s.stop_ch = 2'h3;
            press_ok();
            check("lock cleared", {7'h0, lockout}, 8'h00);
            check("still waiting", {6'h0, outs}, 8'h00);
            press_ok();
            check("rerun", {6'h0, outs}, 8'h03);
        end
        $display("test lamp and reset done");
        in_s.stop_ch = 2'h1;
        repeat (20) @(negedge clock);
        in_s.stop_ch = 2'h3;
        repeat (20) @(negedge clock);
        check("short skew", {7'h0, lockout}, 8'h00);
        in_s.stop_ch = 2'h1;
        expect_lock(CODE_STOP);
        press_ok();
        check("press ignored", {7'h0, lockout}, 8'h01);
        in_s.stop_ch = 2'h0;
        repeat (10) @(negedge clock);
        in_s.stop_ch = 2'h3;
        repeat (12) @(negedge clock);
        check("stop cycled", {7'h0, lockout}, 8'h00);
        $display("test stop done");
        for (k = 0; k < 4; k++) begin
            run_up(1'b0);
            sel = mfs_mute_sel_t'(k);
            r = xs();
            in_s.pair_a[0] = 1'b1;
            repeat (r[4:0]) @(negedge clock);
            in_s.pair_a[1] = 1'b1;
            wait_hi(mute_act, 20);
            repeat (mute_lim(sel) - 3) @(negedge clock);
            check("mute held", {6'h0, lockout, mute_act}, 8'h01);
            if (k == 0) begin
                in_s.pair_a = 2'h0;
                repeat (12) @(negedge clock);
                check("mute ended", {7'h0, mute_act}, 8'h00);
            end else begin
                expect_lock(CODE_MUTE_TIME);
                check("mute dropped", {7'h0, mute_act}, 8'h00);
            end
        end
        run_up(1'b1);
        in_s.pair_b[1] = 1'b1;
        repeat (60) @(negedge clock);
        in_s.pair_b[0] = 1'b1;
        expect_lock(CODE_MUTE_SIM);
        run_up(1'b0);
        in_s.permit = 1'b0;
        repeat (10) @(negedge clock);
        in_s.pair_a = 2'h3;
        expect_lock(CODE_PERMIT);
        $display("test muting done");
        finish_test();
    end
endmodule
